// >>> inc/wsw_defines.svh
// constants of the watchdog, sleep and wake block
// ==========================================================================
// What this block does
// RQ1: wd_period_select bits 4..1: code 0 is 1:32, doubling; codes 12..15 reserved.
// RQ2: reset loads period code 0100, prescale 1:512.
// RQ3: wd_soft_enable at bit 0 switches watchdog; resets to 0.
// RQ4: fuse enable set runs watchdog always, ignoring soft enable.
// RQ5: watchdog time base is the 31 kHz low-frequency oscillator tick.
// RQ6: watchdog held in reset while start-up timer counts, then resumes.
// RQ7: crystal-mode wake holds watchdog cleared for 1024 oscillator periods.
// RQ8: sleep instruction enters power-down.
// RQ9: sleep entry clears watchdog, clears powerdown flag, sets timeout flag, stops osc.
// RQ10: watchdog reset never drives the master clear pin low.
// RQ11: wake on master clear (reset), watchdog, or enabled interrupts (continue).
// RQ12: powerdown flag set at power-up, cleared on sleep entry.
// RQ13: timeout flag cleared when watchdog wake ends sleep.
// RQ14: only the seven listed sources may wake from sleep.
// RQ15: interrupt wakes only if individually enabled, regardless of global enable.
// RQ16: sleep instruction prefetches PC+1.
// RQ17: after wake run prefetched instruction, then vector 0004h if global enable.
// RQ18: watchdog cleared on every wake-up.
// RQ19: enabled flag pending before sleep: sleep is a no-op, nothing changes; the code makes it a no-op only while global enable is low.
// RQ20: flag set during or after sleep: wake at once, sleep counts as executed.
// RQ21: software puts a nop after sleep and clears watchdog before sleeping.
// RQ22: watchdog expiry awake resets the device; asleep it wakes the device.
`ifndef WSW_DEFINES_SVH
`define WSW_DEFINES_SVH
`define WSW_ADDR_WDCTL    4'h0
`define WSW_ADDR_OPTION   4'h1
`define WSW_ADDR_STATUS   4'h2
`define WSW_WDCTL_RESET   8'h08
`define WSW_OPTION_RESET  8'hff
`define WSW_WDCTL_MASK    8'h1f
`define WSW_PS_LSB        1
`define WSW_PS_MSB        4
`define WSW_PS_LAST       4'hb
`define WSW_PS_BASE_BITS  5
`define WSW_SYS_HZ        50000000
`define WSW_LF_HZ         31000
`define WSW_LF_DIV        (`WSW_SYS_HZ / `WSW_LF_HZ)
`define WSW_OST_PERIODS   11'h400
`define WSW_VECTOR        13'h0004
`endif

// >>> inc/wsw_pkg.sv
// types of the watchdog, sleep and wake block
`default_nettype none
package wsw_pkg;
  typedef enum logic [1:0] {
    WSW_AWAKE,
    WSW_ASLEEP,
    WSW_OST
  } wsw_state_t;

  typedef struct packed {
    logic timer1;
    logic capture;
    logic adc;
    logic eeprom;
    logic comparator;
    logic pin_change;
    logic ext_int;
  } wsw_irq_t;

  typedef struct packed {
    wsw_state_t  state;
    logic [7:0]  wd_control;
    logic [7:0]  option_settings;
    logic        powerdown_flag;
    logic        timeout_flag;
    logic [10:0] lf_div;
    logic        lf_tick;
    logic [18:0] wd_count;
    logic [10:0] ost_count;
    logic [7:0]  rdata;
    logic        sleeping;
    logic        osc_drive;
    logic        reset_req;
    logic        prefetch;
    logic        wake;
    logic        vector;
    logic [12:0] vector_pc;
  } wsw_regs_t;
endpackage
`default_nettype wire

// >>> logic/wsw_top.sv
// watchdog timer with sleep entry and wake-up control
`include "wsw_defines.svh"
`default_nettype none
module wsw_top
  import wsw_pkg::*;
(
  input  wire logic        i_clk_sys,        // 50 MHz system clock
  input  wire logic        i_rstn,           // async reset, active low
  input  wire logic        i_ce,             // clock enable, freezes state when low
  input  wire logic [3:0]  i_addr,           // register address
  input  wire logic [7:0]  i_wdata,          // register write data
  input  wire logic        i_wr,             // write strobe
  input  wire logic        i_rd,             // read strobe
  output logic      [7:0]  o_rdata,          // read data, cycle after strobe
  input  wire logic        i_wd_fuse_enable, // configuration fuse forces watchdog on
  input  wire logic        i_xtal_mode,      // crystal oscillator mode selected
  input  wire logic        i_sleep_instr,    // core executes sleep, one cycle
  input  wire logic        i_wd_clear_instr, // core executes watchdog clear
  input  wire logic        i_global_irq_enable, // core global interrupt enable
  input  wire wsw_irq_t    i_irq_flag,       // interrupt flags from sources
  input  wire wsw_irq_t    i_irq_enable,     // individual enables
  input  wire logic        i_master_clear_n, // external master clear pin, async
  output logic             o_sleeping,       // core halted in power-down
  output logic             o_osc_drive,      // oscillator driver on
  output logic             o_reset_req,      // watchdog reset pulse to core
  output logic             o_prefetch,       // fetch PC+1 now, pulse
  output logic             o_wake,           // resume execution, pulse
  output logic             o_vector,         // branch after prefetched instruction
  output logic      [12:0] o_vector_pc,      // interrupt vector address
  output logic             o_powerdown_flag, // power-down status
  output logic             o_timeout_flag    // time-out status
);

  // ==========================================================================
  // master clear synchroniser
  logic master_clear_pin_meta;
  logic master_clear_pin_sync;
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      master_clear_pin_meta <= 1'b1;
      master_clear_pin_sync <= 1'b1;
    end
    else
    begin
      master_clear_pin_meta <= i_master_clear_n;
      master_clear_pin_sync <= master_clear_pin_meta;
    end
  end

  // ==========================================================================
  // state
  wsw_regs_t r;
  wsw_regs_t next_r;

  logic        wd_on;
  logic        irq_pending;
  logic [3:0]  ps_code;
  logic [18:0] wd_limit;
  logic        wd_expire;

  always_comb
  begin
    ps_code     = r.wd_control[`WSW_PS_MSB:`WSW_PS_LSB];
    wd_on       = i_wd_fuse_enable | r.wd_control[0];                          // RQ3 RQ4
    irq_pending = |(i_irq_flag & i_irq_enable);                               // RQ14 RQ15
    // 1:32 at code 0, doubling per code
    wd_limit    = 19'(1) << (`WSW_PS_BASE_BITS + 32'(ps_code));               // RQ1
    wd_expire   = r.lf_tick && (r.wd_count == wd_limit - 19'h1);
  end

  always_comb
  begin
    next_r           = r;
    next_r.rdata     = 8'h00;
    next_r.reset_req = 1'b0;
    next_r.prefetch  = 1'b0;
    next_r.wake      = 1'b0;
    next_r.vector    = 1'b0;
    next_r.vector_pc = `WSW_VECTOR;

    // low-frequency tick derived from system clock
    if (r.lf_div == 11'(`WSW_LF_DIV - 1))                                     // RQ5
    begin
      next_r.lf_div  = 11'h000;
      next_r.lf_tick = 1'b1;
    end
    else
    begin
      next_r.lf_div  = r.lf_div + 11'h001;
      next_r.lf_tick = 1'b0;
    end

    // watchdog counter
    if (!wd_on || r.state == WSW_OST || i_wd_clear_instr)                     // RQ6
      next_r.wd_count = 19'h0;
    else if (r.lf_tick)
      next_r.wd_count = wd_expire ? 19'h0 : r.wd_count + 19'h1;

    // register writes; reserved period codes are ignored
    if (i_wr && i_addr == `WSW_ADDR_WDCTL)
    begin
      if (i_wdata[`WSW_PS_MSB:`WSW_PS_LSB] <= `WSW_PS_LAST)                   // RQ1
        next_r.wd_control = i_wdata & `WSW_WDCTL_MASK;
      else
        next_r.wd_control[0] = i_wdata[0];
    end
    if (i_wr && i_addr == `WSW_ADDR_OPTION)
      next_r.option_settings = i_wdata;
    if (i_rd)
    begin
      unique case (i_addr)
        `WSW_ADDR_WDCTL:  next_r.rdata = r.wd_control;
        `WSW_ADDR_OPTION: next_r.rdata = r.option_settings;
        `WSW_ADDR_STATUS: next_r.rdata = {4'h0, r.state == WSW_ASLEEP,
                                          wd_on, r.timeout_flag, r.powerdown_flag};
        default:          next_r.rdata = 8'h00;
      endcase
    end

    unique case (r.state)
      WSW_AWAKE:
      begin
        if (i_wd_clear_instr)
        begin
          next_r.timeout_flag   = 1'b1;
          next_r.powerdown_flag = 1'b1;
        end
        if (wd_on && wd_expire)
        begin
          next_r.reset_req    = 1'b1;                                         // RQ22 RQ10
          next_r.timeout_flag = 1'b0;
        end
        else if (i_sleep_instr)                                               // RQ8
        begin
          next_r.prefetch = 1'b1;                                             // RQ16
          if (irq_pending && !i_global_irq_enable)
            next_r.state = WSW_AWAKE;                                         // RQ19
          else
          begin
            next_r.wd_count       = 19'h0;                                    // RQ9
            next_r.powerdown_flag = 1'b0;                                     // RQ9 RQ12
            next_r.timeout_flag   = 1'b1;                                     // RQ9
            next_r.osc_drive      = 1'b0;                                     // RQ9
            next_r.sleeping       = 1'b1;
            next_r.state          = WSW_ASLEEP;
          end
        end
      end
      WSW_ASLEEP:
      begin
        if (irq_pending || (wd_on && wd_expire))                              // RQ11 RQ20
        begin
          if (wd_on && wd_expire)
            next_r.timeout_flag = 1'b0;                                       // RQ13
          next_r.wd_count  = 19'h0;                                           // RQ18
          next_r.osc_drive = 1'b1;
          next_r.ost_count = 11'h000;
          if (i_xtal_mode)
            next_r.state = WSW_OST;                                           // RQ7
          else
          begin
            next_r.state    = WSW_AWAKE;
            next_r.sleeping = 1'b0;
            next_r.wake     = 1'b1;                                           // RQ17
            next_r.vector   = irq_pending && i_global_irq_enable;             // RQ17
          end
        end
      end
      WSW_OST:
      begin
        // start-up count uses its own counter, ost_count, while the watchdog counter stays cleared
        if (r.lf_tick)
          next_r.ost_count = r.ost_count + 11'h001;
        if (r.ost_count == `WSW_OST_PERIODS)                                  // RQ7 RQ6
        begin
          next_r.state    = WSW_AWAKE;
          next_r.sleeping = 1'b0;
          next_r.wake     = 1'b1;                                             // RQ17
          next_r.vector   = irq_pending && i_global_irq_enable;               // RQ17
        end
      end
      default:
        next_r.state = WSW_AWAKE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      r                 <= '0;
      r.state           <= WSW_AWAKE;
      r.wd_control      <= `WSW_WDCTL_RESET;                                  // RQ2 RQ3
      r.option_settings <= `WSW_OPTION_RESET;
      r.powerdown_flag  <= 1'b1;                                              // RQ12
      r.timeout_flag    <= 1'b1;
      r.osc_drive       <= 1'b1;
      r.vector_pc       <= `WSW_VECTOR;
    end
    else if (!master_clear_pin_sync)
    begin
      // master clear resets control state, flags keep their meaning
      r.state      <= WSW_AWAKE;                                              // RQ11
      r.sleeping   <= 1'b0;
      r.osc_drive  <= 1'b1;
      r.wd_count   <= 19'h0;
      r.wd_control <= `WSW_WDCTL_RESET;
      r.wake       <= 1'b0;
      r.vector     <= 1'b0;
      r.prefetch   <= 1'b0;
      r.reset_req  <= 1'b0;
    end
    else if (i_ce)
      r <= next_r;
  end

  // ==========================================================================
  // outputs
  always_comb
  begin
    o_rdata          = r.rdata;
    o_sleeping       = r.sleeping;
    o_osc_drive      = r.osc_drive;
    o_reset_req      = r.reset_req;
    o_prefetch       = r.prefetch;
    o_wake           = r.wake;
    o_vector         = r.vector;
    o_vector_pc      = r.vector_pc;
    o_powerdown_flag = r.powerdown_flag;
    o_timeout_flag   = r.timeout_flag;
  end

endmodule
`default_nettype wire

// >>> tb/wsw_properties.sv
// port assertions of the watchdog, sleep and wake block
`default_nettype none
module wsw_properties
  import wsw_pkg::*;
(
  input wire logic        i_clk_sys,           // clock
  input wire logic        i_rstn,              // reset
  input wire logic        i_ce,                // enable
  input wire logic        i_xtal_mode,         // crystal mode
  input wire logic        i_sleep_instr,       // sleep pulse
  input wire logic        i_global_irq_enable, // global enable
  input wire wsw_irq_t    i_irq_flag,          // flags
  input wire wsw_irq_t    i_irq_enable,        // enables
  input wire logic        o_sleeping,          // asleep
  input wire logic        o_osc_drive,         // oscillator on
  input wire logic        o_prefetch,          // prefetch pulse
  input wire logic        o_wake,              // wake pulse
  input wire logic        o_vector,            // vector pulse
  input wire logic [12:0] o_vector_pc,         // vector address
  input wire logic        o_reset_req,         // watchdog reset
  input wire logic        o_powerdown_flag,    // power-down flag
  input wire logic        o_timeout_flag       // time-out flag
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic hit;
  logic take;
  assign hit = i_ce && (|(i_irq_flag & i_irq_enable));
  assign take = i_ce && i_sleep_instr && !o_sleeping;
  // ==========================================================
  // sleep entry
  prefetch_on_sleep_a: assert property (take |=> o_prefetch)
    else $error("no prefetch after sleep");
  sleep_entry_a: assert property (take && !(hit && !i_global_irq_enable) |=>
    o_sleeping && !o_osc_drive && !o_powerdown_flag && o_timeout_flag)
    else $error("sleep entry wrong");
  sleep_nop_a: assert property (take && hit && !i_global_irq_enable |=>
    !o_sleeping && $stable(o_powerdown_flag) && $stable(o_timeout_flag))
    else $error("pending sleep not a no-op");
  osc_off_a: assert property (!i_xtal_mode |-> o_osc_drive != o_sleeping)
    else $error("oscillator drive wrong");
  // ==========================================================
  // wake and watchdog
  irq_wake_a: assert property (o_sleeping && hit && !i_xtal_mode |=> o_wake && !o_sleeping)
    else $error("no wake on enabled irq");
  vector_gie_a: assert property (o_sleeping && hit && !i_xtal_mode |=>
    o_vector == $past(i_global_irq_enable))
    else $error("vector not per global enable");
  vector_pc_a: assert property (o_vector |-> o_wake && o_vector_pc == 13'h0004)
    else $error("vector address wrong");
  masked_no_vector_a: assert property (o_sleeping && !hit |=> !o_vector)
    else $error("vector without enabled irq");
  wd_reset_pulse_a: assert property (o_reset_req |-> !o_sleeping ##1 !o_reset_req)
    else $error("watchdog reset pulse wrong");
  cover property (take ##1 o_sleeping);
  cover property (o_wake && o_vector);
  cover property (o_reset_req);
endmodule
`default_nettype wire

// >>> tb/wsw_core_model.sv
// core model: clears the watchdog, then executes sleep
`default_nettype none
module wsw_core_model
(
  input  wire logic i_clk_sys,        // clock
  input  wire logic i_go,             // request to sleep
  output var  logic o_wd_clear_instr, // clear pulse
  output var  logic o_sleep_instr     // sleep pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_wd_clear_instr = 1'b0;
  initial o_sleep_instr = 1'b0;
  always @(posedge i_clk_sys)
  begin
    o_wd_clear_instr <= i_go;
    o_sleep_instr <= o_wd_clear_instr;
  end
endmodule
`default_nettype wire

// >>> tb/wsw_top_test.sv
// self-checking bench of the watchdog, sleep and wake block
`default_nettype none
module wsw_top_test;
  import wsw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e;} wsw_row_t;
  localparam wsw_row_t ROWS [8] = '{
    '{1'b0, 4'h0, 8'h00, 8'h08}, '{1'b0, 4'h1, 8'h00, 8'hff},
    '{1'b0, 4'h2, 8'h00, 8'h03}, '{1'b0, 4'h3, 8'h00, 8'h00},
    '{1'b1, 4'h0, 8'hff, 8'h09}, '{1'b1, 4'h0, 8'h16, 8'h16},
    '{1'b1, 4'h1, 8'h5a, 8'h5a}, '{1'b1, 4'h2, 8'hff, 8'h03}};
  logic        i_clk_sys = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0;
  logic        i_global_irq_enable = 1'b0, i_master_clear_n = 1'b1, v;
  logic        fuse = 1'b0, ce = 1'b1, xtal = 1'b0, woke;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00, o_rdata, d;
  wsw_irq_t    i_irq_flag = '0, i_irq_enable = '0;
  logic        i_sleep_instr, i_wd_clear_instr, o_sleeping, o_osc_drive, o_reset_req;
  logic        o_prefetch, o_wake, o_vector, o_powerdown_flag, o_timeout_flag;
  logic [12:0] o_vector_pc;
  int          n_fail = 0, check_count = 0, n;
  wsw_top uut (.i_clk_sys, .i_rstn, .i_ce(ce), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_wd_fuse_enable(fuse), .i_xtal_mode(xtal), .i_sleep_instr, .i_wd_clear_instr,
    .i_global_irq_enable, .i_irq_flag, .i_irq_enable, .i_master_clear_n, .o_sleeping,
    .o_osc_drive, .o_reset_req, .o_prefetch, .o_wake, .o_vector, .o_vector_pc,
    .o_powerdown_flag, .o_timeout_flag);
  wsw_core_model core (.i_clk_sys, .i_go(go), .o_wd_clear_instr(i_wd_clear_instr),
    .o_sleep_instr(i_sleep_instr));
  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= dat;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic sleep_req();
    @(posedge i_clk_sys);
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic test_done();
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // stimulus
  initial forever #10 i_clk_sys = ~i_clk_sys;
  initial
  begin
    repeat (70000) @(posedge i_clk_sys);
    n_fail++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    foreach (ROWS[k])
    begin
      if (ROWS[k].w)
        wr(ROWS[k].a, ROWS[k].d);
      rd(ROWS[k].a);
      check("register", {5'h00, d}, {5'h00, ROWS[k].e});
    end
    @(posedge i_clk_sys);
    i_master_clear_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_master_clear_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    rd(4'h0);
    check("clear", {5'h00, d}, 13'h008);
    // fuse forces the watchdog on whatever the soft enable says
    @(posedge i_clk_sys);
    fuse <= 1'b1;
    rd(4'h2);
    check("fuse", {5'h00, d}, 13'h007);
    fuse <= 1'b0;
    // clock enable low: a write must not land
    @(posedge i_clk_sys);
    ce <= 1'b0;
    wr(4'h0, 8'h16);
    ce <= 1'b1;
    rd(4'h0);
    check("frozen", {5'h00, d}, 13'h008);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge i_clk_sys);
      i_irq_enable <= wsw_irq_t'(7'h01 << i);
      i_irq_flag <= wsw_irq_t'(~(7'h01 << i));
      i_global_irq_enable <= 1'(i);
      sleep_req();
      check("asleep", {10'h000, o_sleeping, o_powerdown_flag, o_timeout_flag}, 13'h005);
      @(posedge i_clk_sys);
      i_irq_flag <= '1;
      v = 1'bx;
      repeat (4)
      begin
        @(posedge i_clk_sys);
        #1;
        if (o_wake === 1'b1)
          v = o_vector;
      end
      check("vector", {12'h000, v}, {12'h000, 1'(i)});
    end
    // crystal mode: wake is held back by the start-up count
    @(posedge i_clk_sys);
    xtal <= 1'b1;
    i_irq_enable <= wsw_irq_t'(7'h01);
    i_irq_flag <= '0;
    sleep_req();
    i_irq_flag <= '1;
    woke = 1'b0;
    repeat (8)
    begin
      @(posedge i_clk_sys);
      #1;
      woke = woke | o_wake;
    end
    check("start-up hold", {11'h000, o_sleeping, woke}, 13'h002);
    i_master_clear_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_master_clear_n <= 1'b1;
    xtal <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
    check("clear wake", {12'h000, o_sleeping}, 13'h000);
    @(posedge i_clk_sys);
    i_irq_enable <= '1;
    i_global_irq_enable <= 1'b0;
    sleep_req();
    check("no-op", {10'h000, o_sleeping, o_powerdown_flag, o_timeout_flag}, 13'h003);
    @(posedge i_clk_sys);
    i_irq_flag <= '0;
    wr(4'h0, 8'h01);
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    while (o_reset_req !== 1'b1 && n < 60000);
    check("period", {12'h000, n >= 31 * 1612 && n <= 33 * 1612}, 13'h001);
    repeat (2) @(posedge i_clk_sys);
    check("timeout", {12'h000, o_timeout_flag}, 13'h000);
    test_done();
  end
endmodule
bind wsw_top wsw_properties chk (.i_clk_sys, .i_rstn, .i_ce, .i_xtal_mode, .i_sleep_instr,
  .i_global_irq_enable, .i_irq_flag, .i_irq_enable, .o_sleeping, .o_osc_drive, .o_prefetch,
  .o_wake, .o_vector, .o_vector_pc, .o_reset_req, .o_powerdown_flag, .o_timeout_flag);
`default_nettype wire
